// File: esg_pkg.sv
// Purpose: constants and types for the external step/direction gearing stage
// Assumes: register index addressing, 32-bit data
// Notes: offsets are register indices on the plain register port
package esg_pkg;
  // ****************************************
  // register map
  // ****************************************
  localparam logic [7:0]  ADDR_GLOBAL_CONFIG = 8'h00;
  localparam logic [7:0]  ADDR_GEARING       = 8'h12;
  localparam logic [7:0]  ADDR_START_VEL     = 8'h25;
  localparam logic [7:0]  ADDR_START_ACC     = 8'h2a;
  localparam logic [7:0]  ADDR_POSITION      = 8'h21;
  localparam logic [7:0]  ADDR_TARGET        = 8'h37;
  localparam logic [7:0]  ADDR_HANDOVER_STAT = 8'h3a;
  // ****************************************
  // field positions in global_config, plus mode values, reset words, gearing sign bit and step width
  // ****************************************
  localparam int          MODE_LSB           = 6;
  localparam int          POL_DIR_BIT        = 8;
  localparam int          INDIRECT_BIT       = 9;
  localparam int          AUTO_OFF_BIT       = 26;
  localparam logic [31:0] CONFIG_MASK        = 32'h0400_03c0;
  localparam logic [31:0] RESET_WORD         = 32'h0000_0000;
  localparam logic [31:0] GEAR_RESET         = 32'h0100_0000;
  localparam int          SIGN_BIT           = 31;
  localparam logic [1:0]  MODE_OFF           = 2'h0;
  localparam logic [1:0]  MODE_RISE          = 2'h1;
  localparam logic [1:0]  MODE_FALL          = 2'h2;
  localparam logic [1:0]  MODE_BOTH          = 2'h3;
  localparam logic [7:0]  STEP_WIDTH_CYC     = 8'h02;
  typedef struct packed {
    logic        valid;
    logic        negative;
    logic [31:0] velocity;
    logic [31:0] accel;
    logic [31:0] last_gap;
  } esg_handover_s;
endpackage

// File: esg_gearing.sv
// Purpose: external step/direction input with electronic gearing
// Assumes: single clock, step_input and direction_input asynchronous pins
// Notes: ramp generator lives outside; it takes the handover struct
//
// Local design decision: the plain strobed port.
`timescale 1ns/1ps
// Notes on behaviour
// - mode 01 counts rising step edges
// - mode 10 counts falling step edges
// - mode 11 counts both step edges
// - nonzero mode disables internal step generator
// - polarity bit chooses which level is negative
// - gearing factor signed 8.24 at 0x12
// - each external step adds factor magnitude to accumulator
// - overflow emits one step, keeps residue
// - factor above one gives step bursts
// - negative factor inverts resolved direction
// - indirect mode moves target, not position
// - target direction from sign, polarity, pin
// - indirect when mode nonzero and bit set
// - auto switch-off in direct mode starts ramp at start velocity
// - handover carries cycles since last step
// - start acceleration signed by bit 31
module esg_gearing
(
  input  wire logic                   clk_i,
  input  wire logic                   rst_i,
  input  wire logic                   step_input_i,
  input  wire logic                   direction_input_i,
  input  wire logic [7:0]             addr_i,
  input  wire logic [31:0]            wdata_i,
  input  wire logic                   wr_i,
  input  wire logic                   rd_i,
  output logic      [31:0]            rdata_o,
  output logic                        step_output_o,
  output logic                        dir_output_o,
  output logic                        int_gen_disable_o,
  output esg_pkg::esg_handover_s      handover_o
);
  // ****************************************
  // registers
  // ****************************************
  logic [31:0] config_q;
  logic [31:0] gear_q;
  logic [31:0] start_velocity_q;
  logic [31:0] start_acceleration_q;
  logic [31:0] position_q;
  logic [31:0] target_q;
  logic [31:0] rdata_q;
  logic [2:0]  step_sync_q;
  logic [1:0]  dir_sync_q;
  logic [31:0] accum_q;
  logic [7:0]  pending_q;
  logic        burst_dir_q;
  logic [7:0]  pulse_cnt_q;
  logic        step_out_q;
  logic        dir_out_q;
  logic        gen_off_q;
  logic        last_neg_q;
  logic [31:0] gap_cnt_q;
  logic [31:0] last_gap_q;
  esg_pkg::esg_handover_s handover_q;

  // ****************************************
  // helpers
  // ****************************************
  // write strobe aimed at one register index
  function automatic logic reg_write(input logic wr, input logic [7:0] addr, input logic [7:0] index);
    reg_write = wr && (addr == index);
  endfunction

  // ****************************************
  // decode
  // ****************************************
  wire [1:0]  mode       = config_q[esg_pkg::MODE_LSB +: 2];
  wire        pol_dir    = config_q[esg_pkg::POL_DIR_BIT];
  wire        ext_on     = (mode != esg_pkg::MODE_OFF);
  wire        indirect   = ext_on & config_q[esg_pkg::INDIRECT_BIT];
  wire        auto_off   = config_q[esg_pkg::AUTO_OFF_BIT];
  wire        step_now   = step_sync_q[1];
  wire        step_old   = step_sync_q[2];
  wire        rise       = step_now & ~step_old;
  wire        fall       = ~step_now & step_old;
  wire        ext_step   = ((mode == esg_pkg::MODE_RISE) & rise)
                         | ((mode == esg_pkg::MODE_FALL) & fall)
                         | ((mode == esg_pkg::MODE_BOTH) & (rise | fall));
  wire        gear_neg   = gear_q[esg_pkg::SIGN_BIT];
  wire [31:0] gear_mag   = gear_neg ? (~gear_q + 32'h0000_0001) : gear_q;
  wire        pin_neg    = pol_dir ? dir_sync_q[1] : ~dir_sync_q[1];
  wire        step_neg   = pin_neg ^ gear_neg;
  wire [32:0] accum_sum  = {9'h000, accum_q[23:0]} + {1'b0, gear_mag};
  wire [7:0]  overflows  = accum_sum[31:24];
  wire        pulse_go   = (pending_q != 8'h00) & (pulse_cnt_q == 8'h00) & ext_on & ~indirect;
  wire        wr_config  = reg_write(wr_i, addr_i, esg_pkg::ADDR_GLOBAL_CONFIG);
  wire        wr_gear    = reg_write(wr_i, addr_i, esg_pkg::ADDR_GEARING);
  wire        wr_start_velocity  = reg_write(wr_i, addr_i, esg_pkg::ADDR_START_VEL);
  wire        wr_start_acceleration  = reg_write(wr_i, addr_i, esg_pkg::ADDR_START_ACC);
  wire        wr_pos     = reg_write(wr_i, addr_i, esg_pkg::ADDR_POSITION);
  wire        wr_target  = reg_write(wr_i, addr_i, esg_pkg::ADDR_TARGET);
  wire        gen_off_d  = wr_config ? (wdata_i[esg_pkg::MODE_LSB +: 2] != esg_pkg::MODE_OFF) : ext_on;
  wire        switch_off = wr_config & ext_on
                         & (wdata_i[esg_pkg::MODE_LSB +: 2] == esg_pkg::MODE_OFF) & auto_off;
  wire [31:0] rd_mux     = (addr_i == esg_pkg::ADDR_GLOBAL_CONFIG) ? config_q
                         : (addr_i == esg_pkg::ADDR_GEARING)       ? gear_q
                         : (addr_i == esg_pkg::ADDR_START_VEL)     ? start_velocity_q
                         : (addr_i == esg_pkg::ADDR_START_ACC)     ? start_acceleration_q
                         : (addr_i == esg_pkg::ADDR_POSITION)      ? position_q
                         : (addr_i == esg_pkg::ADDR_TARGET)        ? target_q
                         : (addr_i == esg_pkg::ADDR_HANDOVER_STAT) ? {31'h0000_0000, handover_q.valid}
                         : esg_pkg::RESET_WORD;

  // ****************************************
  // input synchronisers
  // ****************************************
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      step_sync_q <= 3'h0;
      dir_sync_q  <= 2'h0;
    end
    else
    begin
      step_sync_q <= {step_sync_q[1:0], step_input_i};
      dir_sync_q  <= {dir_sync_q[0], direction_input_i};
    end
  end

  // ****************************************
  // register port
  // ****************************************
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      config_q <= esg_pkg::RESET_WORD;
      gear_q   <= esg_pkg::GEAR_RESET;
      start_velocity_q <= esg_pkg::RESET_WORD;
      start_acceleration_q <= esg_pkg::RESET_WORD;
      rdata_q  <= esg_pkg::RESET_WORD;
      gen_off_q <= 1'b0;
    end
    else
    begin
      gen_off_q <= gen_off_d;
      if (wr_config)
        config_q <= wdata_i & esg_pkg::CONFIG_MASK;
      if (wr_gear)
        gear_q <= wdata_i;
      if (wr_start_velocity)
        start_velocity_q <= wdata_i;
      if (wr_start_acceleration)
        start_acceleration_q <= wdata_i;
      rdata_q <= rd_i ? rd_mux : esg_pkg::RESET_WORD;
    end
  end

  // ****************************************
  // gearing accumulator and burst queue
  // ****************************************
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      accum_q     <= esg_pkg::RESET_WORD;
      pending_q   <= 8'h00;
      burst_dir_q <= 1'b0;
      position_q  <= esg_pkg::RESET_WORD;
      target_q    <= esg_pkg::RESET_WORD;
    end
    else if (!ext_on)
    begin
      accum_q   <= esg_pkg::RESET_WORD;
      pending_q <= 8'h00;
      if (wr_target)
        target_q <= wdata_i;
      if (wr_pos)
        position_q <= wdata_i;
    end
    else if (ext_step)
    begin
      accum_q <= {8'h00, accum_sum[23:0]};
      if (indirect)
        target_q <= step_neg ? target_q - {24'h00_0000, overflows}
                             : target_q + {24'h00_0000, overflows};
      else
      begin
        pending_q   <= pending_q + overflows;
        burst_dir_q <= step_neg;
      end
    end
    else if (pulse_go)
    begin
      pending_q  <= pending_q - 8'h01;
      position_q <= burst_dir_q ? position_q - 32'h0000_0001
                                : position_q + 32'h0000_0001;
    end
  end

  // ****************************************
  // step pulse output and handover
  // ****************************************
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pulse_cnt_q <= 8'h00;
      step_out_q  <= 1'b0;
      dir_out_q   <= 1'b0;
      last_neg_q  <= 1'b0;
      gap_cnt_q   <= esg_pkg::RESET_WORD;
      last_gap_q  <= esg_pkg::RESET_WORD;
      handover_q  <= '0;
    end
    else
    begin
      if (pulse_go && !ext_step)
      begin
        pulse_cnt_q <= esg_pkg::STEP_WIDTH_CYC + esg_pkg::STEP_WIDTH_CYC;
        step_out_q  <= 1'b1;
        dir_out_q   <= burst_dir_q;
        last_neg_q  <= burst_dir_q;
        last_gap_q  <= gap_cnt_q;
        gap_cnt_q   <= esg_pkg::RESET_WORD;
      end
      else
      begin
        if (pulse_cnt_q != 8'h00)
          pulse_cnt_q <= pulse_cnt_q - 8'h01;
        if (pulse_cnt_q == esg_pkg::STEP_WIDTH_CYC + 8'h01)
          step_out_q <= 1'b0;
        if (gap_cnt_q != 32'hffff_ffff)
          gap_cnt_q <= gap_cnt_q + 32'h0000_0001;
      end
      if (switch_off && !indirect)
      begin
        handover_q.valid    <= 1'b1;
        handover_q.negative <= last_neg_q;
        handover_q.velocity <= start_velocity_q;
        handover_q.accel    <= start_acceleration_q;
        handover_q.last_gap <= gap_cnt_q;
      end
      else
        handover_q.valid <= 1'b0;
    end
  end

  assign rdata_o           = rdata_q;
  assign step_output_o     = step_out_q;
  assign dir_output_o      = dir_out_q;
  assign int_gen_disable_o = gen_off_q;
  assign handover_o        = handover_q;

  // ****************************************
  // assertions
  // ****************************************
  a_rise_adds: assert property (@(posedge clk_i) disable iff (rst_i)
    (mode == esg_pkg::MODE_RISE && rise && !wr_i) |=> (accum_q[23:0] == $past(accum_sum[23:0])))
    else $error("rising edge not accumulated");
  a_fall_ignored: assert property (@(posedge clk_i) disable iff (rst_i)
    (mode == esg_pkg::MODE_FALL && rise) |-> !ext_step)
    else $error("rising edge taken in falling mode");
  a_both_edges: assert property (@(posedge clk_i) disable iff (rst_i)
    (mode == esg_pkg::MODE_BOTH && (rise || fall)) |-> ext_step)
    else $error("edge missed in toggle mode");
  a_gen_disable: assert property (@(posedge clk_i) disable iff (rst_i)
    (mode != esg_pkg::MODE_OFF) |-> int_gen_disable_o)
    else $error("internal generator not disabled");
  a_indirect_pos: assert property (@(posedge clk_i) disable iff (rst_i)
    (indirect && !wr_i) |=> $stable(position_q))
    else $error("position moved in indirect mode");
  a_target_up: assert property (@(posedge clk_i) disable iff (rst_i)
    (indirect && ext_step && !step_neg) |=> (target_q == $past(target_q) + {24'h00_0000, $past(overflows)}))
    else $error("target not advanced");
  a_step_width: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(step_out_q) |-> step_out_q [*2] ##1 !step_out_q)
    else $error("step pulse width wrong");
  a_handover_vel: assert property (@(posedge clk_i) disable iff (rst_i)
    handover_q.valid |-> (handover_q.velocity == $past(start_velocity_q)))
    else $error("handover velocity wrong");
  a_handover_acc: assert property (@(posedge clk_i) disable iff (rst_i)
    handover_q.valid |-> (handover_q.accel == $past(start_acceleration_q)))
    else $error("handover acceleration wrong");
  c_burst: cover property (@(posedge clk_i) disable iff (rst_i) ext_step && overflows > 8'h01);
  c_indirect: cover property (@(posedge clk_i) disable iff (rst_i) indirect && ext_step);
  c_handover: cover property (@(posedge clk_i) disable iff (rst_i) handover_q.valid);
  c_toggle_fall: cover property (@(posedge clk_i) disable iff (rst_i) mode == esg_pkg::MODE_BOTH && fall);
  c_negative_gear: cover property (@(posedge clk_i) disable iff (rst_i) gear_neg && ext_step);

  // ****************************************
  // edge detection, generator disable and clear when off
  // ****************************************
  a_rise_ignored: assert property (@(posedge clk_i) disable iff (rst_i)
    (mode == esg_pkg::MODE_RISE && fall) |-> !ext_step)
    else $error("falling edge taken in rising mode");
  a_fall_adds: assert property (@(posedge clk_i) disable iff (rst_i)
    (mode == esg_pkg::MODE_FALL && fall && !wr_i) |=> (accum_q[23:0] == $past(accum_sum[23:0])))
    else $error("falling edge not accumulated");
  a_gen_enable: assert property (@(posedge clk_i) disable iff (rst_i)
    (mode == esg_pkg::MODE_OFF) |-> !int_gen_disable_o)
    else $error("internal generator left disabled");
  a_accum_clear: assert property (@(posedge clk_i) disable iff (rst_i)
    !ext_on |=> (accum_q == 32'h0000_0000 && pending_q == 8'h00))
    else $error("accumulator not cleared when off");

  // ****************************************
  // gearing, direction and step pulse output
  // ****************************************
  a_dir_polarity: assert property (@(posedge clk_i) disable iff (rst_i)
    (ext_step && !indirect && !gear_neg) |=> (burst_dir_q == ($past(dir_sync_q[1]) == $past(pol_dir))))
    else $error("direction polarity wrong");
  a_neg_inverts: assert property (@(posedge clk_i) disable iff (rst_i)
    (ext_step && !indirect && gear_neg) |=> (burst_dir_q != ($past(dir_sync_q[1]) == $past(pol_dir))))
    else $error("negative factor did not invert");
  a_residue_kept: assert property (@(posedge clk_i) disable iff (rst_i)
    ext_step |=> (accum_q[23:0] == $past(accum_q[23:0] + gear_mag[23:0])))
    else $error("fraction residue lost");
  a_burst_queue: assert property (@(posedge clk_i) disable iff (rst_i)
    (ext_step && !indirect) |=> (pending_q == $past(pending_q) + $past(overflows)))
    else $error("burst count not queued");
  a_step_low: assert property (@(posedge clk_i) disable iff (rst_i)
    $fell(step_out_q) |-> !step_out_q [*2])
    else $error("step low time too short");
  a_position_step: assert property (@(posedge clk_i) disable iff (rst_i)
    (pulse_go && !ext_step) |=> (position_q - $past(position_q) == ($past(burst_dir_q) ? 32'hffff_ffff : 32'h0000_0001)))
    else $error("position not stepped by one");

  // ****************************************
  // indirect mode and target hold in direct mode
  // ****************************************
  a_target_down: assert property (@(posedge clk_i) disable iff (rst_i)
    (indirect && ext_step && step_neg) |=> (target_q == $past(target_q) - {24'h00_0000, $past(overflows)}))
    else $error("target not lowered");
  a_target_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    (ext_on && !indirect) |=> $stable(target_q))
    else $error("target moved in direct mode");
  a_indirect_quiet: assert property (@(posedge clk_i) disable iff (rst_i)
    indirect |=> !$rose(step_out_q))
    else $error("step pulse in indirect mode");

  // ****************************************
  // handover and register port
  // ****************************************
  a_handover_dir: assert property (@(posedge clk_i) disable iff (rst_i)
    handover_q.valid |-> (handover_q.negative == $past(last_neg_q)))
    else $error("handover direction wrong");
  a_handover_gap: assert property (@(posedge clk_i) disable iff (rst_i)
    handover_q.valid |-> (handover_q.last_gap == $past(gap_cnt_q)))
    else $error("handover spacing wrong");
  a_valid_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
    handover_q.valid |=> !handover_q.valid)
    else $error("handover valid too long");
  a_handover_direct: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr_config && indirect) |=> !handover_q.valid)
    else $error("handover from indirect mode");
  a_config_mask: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_config |=> (config_q == ($past(wdata_i) & esg_pkg::CONFIG_MASK)))
    else $error("config write wrong");
  a_gear_write: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_gear |=> (gear_q == $past(wdata_i)))
    else $error("gearing write lost");
  a_start_velocity_write: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_start_velocity |=> (start_velocity_q == $past(wdata_i)))
    else $error("start velocity write lost");
  a_start_acceleration_write: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_start_acceleration |=> (start_acceleration_q == $past(wdata_i)))
    else $error("start acceleration write lost");
  a_read_gear: assert property (@(posedge clk_i) disable iff (rst_i)
    (rd_i && addr_i == esg_pkg::ADDR_GEARING) |=> (rdata_o == $past(gear_q)))
    else $error("gearing read wrong");
  a_read_pos: assert property (@(posedge clk_i) disable iff (rst_i)
    (rd_i && addr_i == esg_pkg::ADDR_POSITION) |=> (rdata_o == $past(position_q)))
    else $error("position read wrong");
  a_read_idle: assert property (@(posedge clk_i) disable iff (rst_i)
    !rd_i |=> (rdata_o == 32'h0000_0000))
    else $error("read data not idle");
endmodule

// File: esg_step_source.sv
// Purpose: external motion controller model driving step and direction
// Assumes: the bench requests a run with a one-cycle go pulse
// Notes: step line holds its level between edges
`timescale 1ns/1ps
module esg_step_source
(
  input  wire logic       clk_i,
  input  wire logic       go_i,
  input  wire logic [7:0] edges_i,
  input  wire logic       dir_i,
  output logic            step_o,
  output logic            dir_o,
  output logic            busy_o
);
  // ****************************************
  // edge sequencer
  // ****************************************
  logic [7:0] left_q = 8'h00;
  logic [7:0] wait_q = 8'h00;
  logic       step_q = 1'b0;
  logic       dir_q  = 1'b0;
  always @(posedge clk_i)
  begin
    if (go_i)
    begin
      left_q <= edges_i;
      wait_q <= 8'h40;
      dir_q  <= dir_i;
    end
    else if (left_q != 8'h00)
    begin
      if (wait_q == 8'h00)
      begin
        step_q <= ~step_q;
        left_q <= left_q - 8'h01;
        wait_q <= 8'h40;
      end
      else
        wait_q <= wait_q - 8'h01;
    end
  end
  assign step_o = step_q;
  assign dir_o  = dir_q;
  assign busy_o = go_i || (left_q != 8'h00);
endmodule

// File: esg_tb.sv
// Purpose: self-checking bench for the gearing stage
// Assumes: register reads answer one cycle after the strobe
// Notes: step model spaces every edge by 65 cycles
`timescale 1ns/1ps
module testbench;
  // ****************************************
  // signals
  // ****************************************
  logic                   clk_i = 1'b0;
  logic                   rst_i = 1'b1;
  logic [7:0]             addr_i = 8'h00;
  logic [31:0]            wdata_i = 32'h0000_0000;
  logic                   wr_i = 1'b0;
  logic                   rd_i = 1'b0;
  logic                   go = 1'b0;
  logic [7:0]             edges = 8'h00;
  logic                   dir = 1'b0;
  logic [31:0]            rdata_o;
  logic                   step_output_o;
  logic                   dir_output_o;
  logic                   int_gen_disable_o;
  esg_pkg::esg_handover_s handover_o;
  logic                   step_line;
  logic                   dir_line;
  logic                   busy;
  logic [31:0]            pulses = 32'h0000_0000;
  logic                   prev_step = 1'b0;
  int                     miscompares = 0;
  int                     checked = 0;
  int                     cycles = 0;
  always #20 clk_i = ~clk_i;
  esg_gearing DUT (.clk_i(clk_i), .rst_i(rst_i), .step_input_i(step_line), .direction_input_i(dir_line),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .step_output_o(step_output_o), .dir_output_o(dir_output_o), .int_gen_disable_o(int_gen_disable_o),
    .handover_o(handover_o));
  esg_step_source src (.clk_i(clk_i), .go_i(go), .edges_i(edges), .dir_i(dir), .step_o(step_line),
    .dir_o(dir_line), .busy_o(busy));
  always @(posedge clk_i)
  begin
    cycles <= cycles + 1;
    prev_step <= step_output_o;
    if (step_output_o && !prev_step)
      pulses <= pulses + 32'h0000_0001;
    if (cycles == 30000)
    begin
      miscompares++;
      stop_test();
    end
  end
  // ****************************************
  // shared tasks
  // ****************************************
  task automatic stop_test();
    $display("checked=%0d miscompares=%0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1;
    d = rdata_o;
  endtask
  task automatic steps(input logic [7:0] n, input logic d);
    @(posedge clk_i);
    go <= 1'b1;
    edges <= n;
    dir <= d;
    @(posedge clk_i);
    go <= 1'b0;
    for (int i = 0; i < 2000 && busy; i++)
      @(posedge clk_i);
    repeat (60) @(posedge clk_i);
  endtask
  function automatic logic [31:0] cfg(input logic [1:0] m, input logic p, input logic ind, input logic a);
    cfg = 32'h0000_0000;
    cfg[esg_pkg::MODE_LSB +: 2] = m;
    cfg[esg_pkg::POL_DIR_BIT] = p;
    cfg[esg_pkg::INDIRECT_BIT] = ind;
    cfg[esg_pkg::AUTO_OFF_BIT] = a;
  endfunction
  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_regs();
    logic [31:0] v;
    rd(esg_pkg::ADDR_GLOBAL_CONFIG, v);
    chk(v, 32'h0000_0000);
    rd(esg_pkg::ADDR_GEARING, v);
    chk(v, esg_pkg::GEAR_RESET);
    wr(esg_pkg::ADDR_GEARING, 32'hfe80_0000);
    rd(esg_pkg::ADDR_GEARING, v);
    chk(v, 32'hfe80_0000);
    rd(8'h05, v);
    chk(v, 32'h0000_0000);
  endtask
  task automatic t_modes();
    logic [31:0] p0, p1, n0;
    wr(esg_pkg::ADDR_GEARING, 32'h0100_0000);
    for (int m = 1; m < 4; m++)
    begin
      wr(esg_pkg::ADDR_GLOBAL_CONFIG, cfg(m[1:0], 1'b0, 1'b0, 1'b0));
      chk({31'h0, int_gen_disable_o}, 32'h0000_0001);
      rd(esg_pkg::ADDR_POSITION, p0);
      n0 = pulses;
      steps(8'h04, 1'b1);
      chk(pulses - n0, (m == 3) ? 32'h0000_0004 : 32'h0000_0002);
      rd(esg_pkg::ADDR_POSITION, p1);
      chk(p1 - p0, (m == 3) ? 32'h0000_0004 : 32'h0000_0002);
      chk({31'h0, dir_output_o}, 32'h0000_0000);
    end
    wr(esg_pkg::ADDR_GLOBAL_CONFIG, 32'h0000_0000);
    chk({31'h0, int_gen_disable_o}, 32'h0000_0000);
  endtask
  task automatic t_burst();
    logic [31:0] p0, p1, n0;
    rd(esg_pkg::ADDR_POSITION, p0);
    wr(esg_pkg::ADDR_GLOBAL_CONFIG, cfg(2'h1, 1'b1, 1'b0, 1'b0));
    wr(esg_pkg::ADDR_GEARING, 32'h0280_0000);
    n0 = pulses;
    steps(8'h04, 1'b0);
    chk(pulses - n0, 32'h0000_0005);
    chk({31'h0, dir_output_o}, 32'h0000_0000);
    steps(8'h02, 1'b1);
    chk(pulses - n0, 32'h0000_0007);
    chk({31'h0, dir_output_o}, 32'h0000_0001);
    rd(esg_pkg::ADDR_POSITION, p1);
    chk(p1 - p0, 32'h0000_0003);
    wr(esg_pkg::ADDR_GEARING, 32'hff00_0000);
    n0 = pulses;
    steps(8'h02, 1'b1);
    chk(pulses - n0, 32'h0000_0001);
    chk({31'h0, dir_output_o}, 32'h0000_0000);
    wr(esg_pkg::ADDR_GLOBAL_CONFIG, 32'h0000_0000);
  endtask
  task automatic t_indirect();
    logic [31:0] p0, v;
    wr(esg_pkg::ADDR_TARGET, 32'h0000_0010);
    wr(esg_pkg::ADDR_GEARING, 32'h0100_0000);
    rd(esg_pkg::ADDR_POSITION, p0);
    wr(esg_pkg::ADDR_GLOBAL_CONFIG, cfg(2'h1, 1'b0, 1'b1, 1'b0));
    steps(8'h04, 1'b0);
    wr(esg_pkg::ADDR_GLOBAL_CONFIG, 32'h0000_0000);
    rd(esg_pkg::ADDR_TARGET, v);
    chk(v, 32'h0000_000e);
    rd(esg_pkg::ADDR_POSITION, v);
    chk(v, p0);
  endtask
  task automatic t_handover();
    wr(esg_pkg::ADDR_START_VEL, 32'h0000_1234);
    wr(esg_pkg::ADDR_START_ACC, 32'h8000_0040);
    wr(esg_pkg::ADDR_GLOBAL_CONFIG, cfg(2'h1, 1'b0, 1'b0, 1'b1));
    steps(8'h02, 1'b0);
    wr(esg_pkg::ADDR_GLOBAL_CONFIG, cfg(2'h0, 1'b0, 1'b0, 1'b1));
    for (int i = 0; i < 4 && handover_o.valid !== 1'b1; i++)
      @(posedge clk_i) #1;
    chk({31'h0, handover_o.valid}, 32'h0000_0001);
    chk(handover_o.velocity, 32'h0000_1234);
    chk({31'h0, handover_o.negative}, 32'h0000_0001);
    chk(handover_o.accel, 32'h8000_0040);
    chk({31'h0, handover_o.last_gap != 32'h0}, 32'h0000_0001);
    wr(esg_pkg::ADDR_START_ACC, 32'h0000_0000);
    wr(esg_pkg::ADDR_GLOBAL_CONFIG, cfg(2'h1, 1'b0, 1'b0, 1'b1));
    steps(8'h02, 1'b1);
    wr(esg_pkg::ADDR_GLOBAL_CONFIG, cfg(2'h0, 1'b0, 1'b0, 1'b1));
    chk({31'h0, handover_o.valid}, 32'h0000_0001);
    chk({31'h0, handover_o.negative}, 32'h0000_0000);
    chk(handover_o.accel, 32'h0000_0000);
  endtask
  initial
  begin
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    t_regs();
    t_modes();
    t_burst();
    t_indirect();
    t_handover();
    stop_test();
  end
endmodule
